// File: src/ssd_pkg.sv
// package of constants and carrier types for the self-supervision diagnostics block
package ssd_pkg;

  // number of alarm groups and diagnostic sources
  localparam int unsigned NUM_GROUPS      = 3;
  localparam int unsigned NUM_SOURCES     = 20;
  localparam int unsigned NUM_RELAYS      = 24;
  localparam int unsigned NUM_ALARM_OUTS  = 5;
  localparam int unsigned NUM_HW_FAULTS   = 10;
  localparam int unsigned NUM_OUTPUTS     = 16;

  // register indices of the four diagnostic registers
  localparam logic [1:0] REG_RELAY_LOW  = 2'h0;
  localparam logic [1:0] REG_RELAY_HIGH = 2'h1;
  localparam logic [1:0] REG_RESERVED   = 2'h2;
  localparam logic [1:0] REG_HW_FAULTS  = 2'h3;

  // field positions in the first diagnostic register
  localparam int unsigned RLOW_RELAY_POS = 2;
  localparam int unsigned RLOW_ALARM_POS = 10;
  localparam int unsigned RLOW_RELAY9_POS = 15;

  // field positions in the hardware fault register
  localparam int unsigned HW_SUPPLY_POS  = 0;
  localparam int unsigned HW_BUSBUF_POS  = 1;
  localparam int unsigned HW_ORDER_POS   = 2;
  localparam int unsigned HW_CARD_POS    = 3;
  localparam int unsigned HW_PLCONF_POS  = 4;
  localparam int unsigned HW_ARCIO_POS   = 5;
  localparam int unsigned HW_ARCSNS_POS  = 6;
  localparam int unsigned HW_MEMCARD_POS = 7;
  localparam int unsigned HW_ARCBI_POS   = 8;
  localparam int unsigned HW_LOW_AUX_SUPPLY_POS  = 9;

  // reset values of configuration
  localparam logic [2:0] HEALTH_LINK_RST = 3'h2;   // only group two linked
  localparam logic [1:0] SRC_GROUP_RST   = 2'h0;   // every source in group one

  // event codes reported with on/off events
  localparam logic [7:0] DIAG_ON_EVENT  = 8'h38;
  localparam logic [7:0] DIAG_OFF_EVENT = 8'h39;

  // watchdog timing: restart pulse and retry window
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned WD_TIMEOUT_US   = 100;
  localparam int unsigned WD_TIMEOUT_CYC  = WD_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RESTART_US      = 10;
  localparam int unsigned RESTART_CYC     = RESTART_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RECOVER_US      = 1000;
  localparam int unsigned RECOVER_CYC     = RECOVER_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BOOT_CYC        = 16;

  // watchdog states
  typedef enum logic [2:0] {
    WD_BOOT,
    WD_RUN,
    WD_RESTART,
    WD_WAIT,
    WD_DEAD
  } ssd_wd_state_type;

  // event record put out with a one-cycle strobe
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [4:0] source;
  } ssd_event_type;

  // register read port
  typedef struct packed {
    logic        rd;
    logic [1:0]  idx;
  } ssd_rd_req_type;

endpackage

// File: src/ssd_watchdog.sv
// watchdog that restarts a stalled controller and flags a permanent fault
`timescale 1ns/10ps
module ssd_watchdog
  import ssd_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = WD_TIMEOUT_CYC,
  parameter int unsigned RESTART_LEN = RESTART_CYC,
  parameter int unsigned RECOVER_LEN = RECOVER_CYC
) (
  input  wire logic mclk_i,        // system clock
  input  wire logic rst_i,         // synchronous reset
  input  wire logic kick_i,        // controller alive pulse
  input  wire logic boot_ok_i,     // boot self-test passed
  output logic      restart_o,     // restart request to controller
  output logic      perm_fault_o   // permanent internal fault
);

  typedef struct packed {
    ssd_wd_state_type state;
    logic [31:0]      cnt;
    logic             restart;
    logic             perm;
  } wd_state_type;

  wd_state_type cur_r;
  wd_state_type cur_nxt;

  // restart once; a second silence after restart is permanent
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.cnt = cur_r.cnt + 32'h1;
    case (cur_r.state)
      WD_BOOT: begin
        if (boot_ok_i) begin
          cur_nxt.state = WD_RUN;
          cur_nxt.cnt = 32'h0;
        end else if (cur_r.cnt >= 32'(BOOT_CYC + TIMEOUT_CYC)) begin
          cur_nxt.state = WD_DEAD;
        end
      end
      WD_RUN: begin
        if (kick_i) begin
          cur_nxt.cnt = 32'h0;
        end else if (cur_r.cnt >= 32'(TIMEOUT_CYC - 1)) begin
          cur_nxt.state = WD_RESTART;
          cur_nxt.cnt = 32'h0;
          cur_nxt.restart = 1'b1;
        end
      end
      WD_RESTART: begin
        if (cur_r.cnt >= 32'(RESTART_LEN - 1)) begin
          cur_nxt.state = WD_WAIT;
          cur_nxt.cnt = 32'h0;
          cur_nxt.restart = 1'b0;
        end
      end
      WD_WAIT: begin
        if (kick_i) begin
          cur_nxt.state = WD_RUN;
          cur_nxt.cnt = 32'h0;
        end else if (cur_r.cnt >= 32'(RECOVER_LEN - 1)) begin
          cur_nxt.state = WD_DEAD;
        end
      end
      WD_DEAD: begin
        cur_nxt.cnt = cur_r.cnt;   // only a reset leaves this state
      end
      default: begin
        cur_nxt.state = WD_DEAD;
      end
    endcase
    cur_nxt.perm = (cur_nxt.state == WD_DEAD);
    if (rst_i) begin
      cur_nxt = '{state: WD_BOOT, cnt: 32'h0, restart: 1'b0, perm: 1'b0};
    end
  end

  always_ff @(posedge mclk_i) begin
    cur_r <= cur_nxt;
  end

  assign restart_o    = cur_r.restart;
  assign perm_fault_o = cur_r.perm;

endmodule

// File: src/ssd_top.sv
// self-supervision: watchdog, alarm grouping, health contact, events, diagnostic registers
//
// What this block does
// - stalled controller is restarted once; failed restart flags a permanent fault
// - permanent fault blocks all output relays except the health contact
// - internal supply voltage faults are supervised
// - health contact energized only with supply present and device fully operational
// - each alarm source picks one of three groups; selected groups drive health
// - after reset only group two is linked to the health contact
// - each alarm group routes through the output matrix to any output
// - self-tests run during boot and continue at run time
// - permanent fault releases health contact, lights status, shows panel fault
// - temporary fault sets matrix signal and emits on event code
// - clearing of temporary fault emits off event code
// - latched diagnostic state clears only on local panel reset command
// - four 16-bit diagnostic registers readable by remote master
// - register one: bits 2..9 relays 1-8, 10..14 alarms, 15 relay 9
// - register two: bits 0..14 relays 10 to 24 ascending
// - register four bits 0..3: supply, bus buffer, order code, option card
// - register four bits 4..9: logic config, arc io, sensor, card, bi, aux
// - each event carries the code of its diagnostic source
`timescale 1ns/10ps
module ssd_top
  import ssd_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = WD_TIMEOUT_CYC,
  parameter int unsigned RESTART_LEN = RESTART_CYC,
  parameter int unsigned RECOVER_LEN = RECOVER_CYC
) (
  input  wire logic                       mclk_i,          // system clock
  input  wire logic                       rst_i,           // synchronous reset
  input  wire logic                       kick_i,          // controller alive pulse
  input  wire logic                       boot_ok_i,       // boot self-test passed
  input  wire logic                       supply_ok_i,     // auxiliary supply present
  input  wire logic [NUM_SOURCES-1:0]     alarm_src_i,     // run-time alarm sources
  input  wire logic [NUM_RELAYS-1:0]      relay_fault_i,   // output relay faults
  input  wire logic [NUM_ALARM_OUTS-1:0]  alarm_out_fault_i, // alarm output faults
  input  wire logic [NUM_HW_FAULTS-1:0]   hw_fault_i,      // hardware fault inputs
  input  wire logic                       cfg_we_i,        // configuration write
  input  wire logic [4:0]                 cfg_src_i,       // source to assign
  input  wire logic [1:0]                 cfg_group_i,     // group index 0..2
  input  wire logic                       link_we_i,       // health link write
  input  wire logic [NUM_GROUPS-1:0]      link_i,          // groups linked to health
  input  wire logic                       mtx_we_i,        // matrix write
  input  wire logic [1:0]                 mtx_group_i,     // matrix row
  input  wire logic [NUM_OUTPUTS-1:0]     mtx_row_i,       // outputs for that row
  input  wire logic                       panel_reset_i,   // local panel reset command
  input  wire logic [NUM_OUTPUTS-1:0]     out_req_i,       // protection output requests
  input  wire ssd_rd_req_type             rd_req_i,        // register read request
  output logic [15:0]                     rd_data_o,       // register read data
  output logic                            rd_valid_o,      // read data valid
  output logic                            restart_o,       // controller restart
  output logic                            health_o,        // health contact energized
  output logic                            status_led_o,    // fault status indicator
  output logic                            panel_fault_o,   // panel fault message
  output logic [NUM_GROUPS-1:0]           group_o,         // alarm group matrix signals
  output logic [NUM_OUTPUTS-1:0]          out_o,           // outputs after matrix and block
  output ssd_event_type                   event_o          // on/off event strobe
);

  typedef struct packed {
    logic [NUM_SOURCES-1:0][1:0]          grp_sel;
    logic [NUM_GROUPS-1:0]                link;
    logic [NUM_GROUPS-1:0][NUM_OUTPUTS-1:0] mtx;
    logic [NUM_SOURCES-1:0]               latched;
    logic [NUM_SOURCES-1:0]               prev;
    logic [NUM_SOURCES-1:0]               pend_on;
    logic [NUM_SOURCES-1:0]               pend_off;
    logic [15:0]                          rd_data;
    logic                                 rd_valid;
    logic                                 health;
    logic [NUM_GROUPS-1:0]                group;
    logic [NUM_OUTPUTS-1:0]               out;
    ssd_event_type                        evt;
  } top_state_type;

  top_state_type cur_r;
  top_state_type cur_nxt;
  logic          perm_fault;

  // watchdog over the controller
  ssd_watchdog #(
    .TIMEOUT_CYC (TIMEOUT_CYC),
    .RESTART_LEN (RESTART_LEN),
    .RECOVER_LEN (RECOVER_LEN)
  ) u_wd (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .kick_i       (kick_i),
    .boot_ok_i    (boot_ok_i),
    .restart_o    (restart_o),
    .perm_fault_o (perm_fault)
  );

  // all sources: run-time alarms plus supply faults folded in
  logic [NUM_SOURCES-1:0] src_all;
  logic [15:0]            reg_relay_low;
  logic [15:0]            reg_relay_high;
  logic [15:0]            reg_hw;

  // internal supply and low aux feed source 8 and 9 alongside their own inputs
  always_comb begin
    src_all = alarm_src_i;
    src_all[8] = alarm_src_i[8] | hw_fault_i[HW_SUPPLY_POS];
    src_all[9] = alarm_src_i[9] | hw_fault_i[HW_LOW_AUX_SUPPLY_POS];
  end

  // diagnostic register images, built field by field; unused bits stay zero
  always_comb begin
    reg_relay_low  = 16'h0;
    reg_relay_high = 16'h0;
    reg_hw         = 16'h0;

    // relays one to eight sit above the two reserved bits
    for (int b = 0; b < 8; b++) begin
      reg_relay_low[RLOW_RELAY_POS + b] = relay_fault_i[b];
    end
    // alarm outputs one to five follow the relays
    for (int b = 0; b < int'(NUM_ALARM_OUTS); b++) begin
      reg_relay_low[RLOW_ALARM_POS + b] = alarm_out_fault_i[b];
    end
    // relay nine takes the top bit, out of order with the others
    reg_relay_low[RLOW_RELAY9_POS] = relay_fault_i[8];

    // relays ten to twenty-four fill the second register from bit zero
    for (int b = 0; b < int'(NUM_RELAYS) - 9; b++) begin
      reg_relay_high[b] = relay_fault_i[9 + b];
    end

    // hardware faults keep their own positions in the fourth register
    reg_hw[HW_SUPPLY_POS]  = hw_fault_i[HW_SUPPLY_POS];
    reg_hw[HW_BUSBUF_POS]  = hw_fault_i[HW_BUSBUF_POS];
    reg_hw[HW_ORDER_POS]   = hw_fault_i[HW_ORDER_POS];
    reg_hw[HW_CARD_POS]    = hw_fault_i[HW_CARD_POS];
    reg_hw[HW_PLCONF_POS]  = hw_fault_i[HW_PLCONF_POS];
    reg_hw[HW_ARCIO_POS]   = hw_fault_i[HW_ARCIO_POS];
    reg_hw[HW_ARCSNS_POS]  = hw_fault_i[HW_ARCSNS_POS];
    reg_hw[HW_MEMCARD_POS] = hw_fault_i[HW_MEMCARD_POS];
    reg_hw[HW_ARCBI_POS]   = hw_fault_i[HW_ARCBI_POS];
    reg_hw[HW_LOW_AUX_SUPPLY_POS]  = hw_fault_i[HW_LOW_AUX_SUPPLY_POS];
  end

  // alarm group activity, contact conditions and matrix pull-in
  logic [NUM_GROUPS-1:0]  grp_act;
  logic                   linked_alarm;
  logic                   contact_ok;
  logic [NUM_OUTPUTS-1:0] matrix_out;

  // a group is active while any latched source assigned to it is set
  always_comb begin
    grp_act = '0;
    for (int i = 0; i < int'(NUM_SOURCES); i++) begin
      if (cur_r.latched[i] && (cur_r.grp_sel[i] < 2'h3)) begin
        grp_act[cur_r.grp_sel[i]] = 1'b1;
      end
    end
  end

  // linked groups combine by or; any one of them releases the contact
  assign linked_alarm = |(grp_act & cur_r.link);
  // fail-safe: the contact needs supply, a live controller and no linked alarm
  assign contact_ok   = supply_ok_i && !perm_fault && !linked_alarm;

  // outputs that active groups pull in through the matrix
  always_comb begin
    matrix_out = '0;
    for (int g = 0; g < int'(NUM_GROUPS); g++) begin
      if (grp_act[g]) begin
        matrix_out = matrix_out | cur_r.mtx[g];
      end
    end
  end

  // edges of the folded sources against their value one cycle ago
  logic [NUM_SOURCES-1:0] src_rise;
  logic [NUM_SOURCES-1:0] src_fall;
  assign src_rise = src_all & ~cur_r.prev;
  assign src_fall = ~src_all & cur_r.prev;

  // one pending event leaves per cycle
  logic                   pick_on;
  logic                   pick_off;
  logic [4:0]             pick_idx;
  always_comb begin
    pick_on  = 1'b0;
    pick_off = 1'b0;
    pick_idx = 5'h0;
    // ons go first, lowest index wins
    for (int i = int'(NUM_SOURCES) - 1; i >= 0; i--) begin
      if (cur_r.pend_on[i]) begin
        pick_on  = 1'b1;
        pick_idx = 5'(i);
      end
    end

    // offs only when no on waits, so an off never overtakes its own on
    if (!pick_on) begin
      for (int i = int'(NUM_SOURCES) - 1; i >= 0; i--) begin
        if (cur_r.pend_off[i]) begin
          pick_off = 1'b1;
          pick_idx = 5'(i);
        end
      end
    end
  end

  // main next-state logic
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.evt = '0;
    cur_nxt.rd_valid = 1'b0;

    // source to group assignment; a source or group out of range is ignored
    if (cfg_we_i && (cfg_src_i < 5'(NUM_SOURCES)) && (cfg_group_i < 2'h3)) begin
      cur_nxt.grp_sel[cfg_src_i] = cfg_group_i;
    end

    // groups linked to the health contact
    if (link_we_i) begin
      cur_nxt.link = link_i;
    end

    // one matrix row per alarm group
    if (mtx_we_i && (mtx_group_i < 2'h3)) begin
      cur_nxt.mtx[mtx_group_i] = mtx_row_i;
    end

    // latched state: panel reset clears, a live source sets again (set wins)
    if (panel_reset_i) begin
      cur_nxt.latched = '0;
    end
    cur_nxt.latched = cur_nxt.latched | src_all;
    cur_nxt.prev = src_all;

    // edges queue on and off events; one event leaves per cycle
    if (pick_on) begin
      cur_nxt.evt = '{valid: 1'b1, code: DIAG_ON_EVENT, source: pick_idx};
      cur_nxt.pend_on[pick_idx] = 1'b0;
    end else if (pick_off) begin
      cur_nxt.evt = '{valid: 1'b1, code: DIAG_OFF_EVENT, source: pick_idx};
      cur_nxt.pend_off[pick_idx] = 1'b0;
    end
    // a fresh edge sets its flag after the clear, so it is never lost
    cur_nxt.pend_on  = cur_nxt.pend_on  | src_rise;
    cur_nxt.pend_off = cur_nxt.pend_off | src_fall;

    // group activity from latched sources
    cur_nxt.group = grp_act;

    // fail-safe contact: any linked active group, lost supply or permanent fault drops it
    cur_nxt.health = contact_ok;

    // outputs: protection requests plus matrix rows, blocked on permanent fault
    cur_nxt.out = out_req_i | matrix_out;
    if (perm_fault) begin
      cur_nxt.out = '0;
    end

    // register reads answer one cycle later
    if (rd_req_i.rd) begin
      cur_nxt.rd_valid = 1'b1;
      case (rd_req_i.idx)
        REG_RELAY_LOW: begin
          cur_nxt.rd_data = reg_relay_low;
        end
        REG_RELAY_HIGH: begin
          cur_nxt.rd_data = reg_relay_high;
        end
        REG_HW_FAULTS: begin
          cur_nxt.rd_data = reg_hw;
        end
        default: begin
          cur_nxt.rd_data = 16'h0;
        end
      endcase
    end

    // reset: empty state, every source in group one, only group two on the contact
    if (rst_i) begin
      cur_nxt = '0;
      for (int i = 0; i < NUM_SOURCES; i++) begin
        cur_nxt.grp_sel[i] = SRC_GROUP_RST;
      end
      cur_nxt.link = HEALTH_LINK_RST;
    end
  end

  always_ff @(posedge mclk_i) begin
    cur_r <= cur_nxt;
  end

  // read port
  assign rd_data_o     = cur_r.rd_data;
  assign rd_valid_o    = cur_r.rd_valid;

  // contact and fault indicators; the indicators follow the watchdog flop directly
  assign health_o      = cur_r.health;
  assign status_led_o  = perm_fault;
  assign panel_fault_o = perm_fault;

  // group signals, routed outputs and the event strobe
  assign group_o       = cur_r.group;
  assign out_o         = cur_r.out;
  assign event_o       = cur_r.evt;

endmodule

// File: tb/ssd_top_props.sv
// concurrent checks on the ports of the self-supervision block
`timescale 1ns/10ps
module ssd_top_props
  import ssd_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = WD_TIMEOUT_CYC,
  parameter int unsigned RESTART_LEN = RESTART_CYC,
  parameter int unsigned RECOVER_LEN = RECOVER_CYC
) (
  input wire logic                      mclk_i,            // clock
  input wire logic                      rst_i,             // reset
  input wire logic                      supply_ok_i,       // aux supply
  input wire logic [NUM_RELAYS-1:0]     relay_fault_i,     // relay faults
  input wire logic [NUM_ALARM_OUTS-1:0] alarm_out_fault_i, // alarm out faults
  input wire logic [NUM_HW_FAULTS-1:0]  hw_fault_i,        // hw faults
  input wire ssd_rd_req_type            rd_req_i,          // read request
  input wire logic [15:0]               rd_data_o,         // read data
  input wire logic                      rd_valid_o,        // read valid
  input wire logic                      health_o,          // health contact
  input wire logic                      status_led_o,      // status led
  input wire logic                      panel_fault_o,     // panel message
  input wire logic                      restart_o,         // restart
  input wire logic [NUM_OUTPUTS-1:0]    out_o,             // outputs
  input wire ssd_event_type             event_o            // events
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // read port: one answer exactly one cycle after each request
  rd_answer_a: assert property (rd_req_i.rd |=> rd_valid_o)
    else $error("read not answered");
  rd_single_a: assert property (!rd_req_i.rd |=> !rd_valid_o)
    else $error("read valid without request");
  // register images use the inputs seen at the request edge
  reg_low_a: assert property (rd_req_i.rd && rd_req_i.idx == REG_RELAY_LOW |=>
    rd_data_o == {$past(relay_fault_i[8]), $past(alarm_out_fault_i), $past(relay_fault_i[7:0]), 2'h0})
    else $error("first register image wrong");
  reg_high_a: assert property (rd_req_i.rd && rd_req_i.idx == REG_RELAY_HIGH |=>
    rd_data_o == {1'h0, $past(relay_fault_i[23:9])}) else $error("second register image wrong");
  reg_rsvd_a: assert property (rd_req_i.rd && rd_req_i.idx == REG_RESERVED |=>
    rd_data_o == 16'h0000) else $error("reserved register not zero");
  reg_hw_a: assert property (rd_req_i.rd && rd_req_i.idx == REG_HW_FAULTS |=>
    rd_data_o == {6'h00, $past(hw_fault_i)}) else $error("hardware register image wrong");
  // a permanent fault blocks outputs and drops the contact
  perm_block_a: assert property (status_led_o |=> out_o == 16'h0000 && !health_o)
    else $error("outputs not blocked on permanent fault");
  panel_match_a: assert property (panel_fault_o == status_led_o)
    else $error("panel message differs from status led");
  supply_drop_a: assert property (!supply_ok_i |-> ##[1:2] !health_o)
    else $error("health held without supply");
  event_code_a: assert property (event_o.valid |->
    (event_o.code == DIAG_ON_EVENT || event_o.code == DIAG_OFF_EVENT) && event_o.source < 5'(NUM_SOURCES))
    else $error("event record malformed");

  cover property (rd_req_i.rd ##1 rd_valid_o);
  cover property (event_o.valid);
  cover property ($rose(restart_o));
  cover property ($rose(status_led_o));
endmodule

// File: tb/ssd_ctrl_model.sv
// controller stand-in that kicks the watchdog unless told to stall
`timescale 1ns/10ps
module ssd_ctrl_model #(
  parameter int unsigned KICK_GAP = 4
) (
  input  wire logic mclk_i,   // clock
  input  wire logic stall_i,  // controller hung
  output logic      kick_o    // alive pulse
);
  int unsigned cnt_r = 0;

  // free-running gap counter; a short gap keeps kicks well inside the timeout
  always_ff @(posedge mclk_i) begin
    cnt_r <= (cnt_r == KICK_GAP - 1) ? 0 : cnt_r + 1;
  end
  assign kick_o = !stall_i && cnt_r == 0;
endmodule

// File: tb/ssd_top_bench.sv
// self-checking bench of the self-supervision diagnostics block
`timescale 1ns/10ps
module ssd_top_bench;
  import ssd_pkg::*;
  logic mclk_i = 1'b0, rst_i = 1'b1, kick_i, boot_ok_i = 1'b1, supply_ok_i = 1'b1, stall = 1'b0;
  logic [19:0] alarm_src_i = 20'h0;
  logic [23:0] relay_fault_i = 24'h0;
  logic [4:0] alarm_out_fault_i = 5'h0, cfg_src_i = 5'h0;
  logic [9:0] hw_fault_i = 10'h0;
  logic cfg_we_i = 1'b0, link_we_i = 1'b0, mtx_we_i = 1'b0, panel_reset_i = 1'b0;
  logic [1:0] cfg_group_i = 2'h0, mtx_group_i = 2'h0;
  logic [2:0] link_i = 3'h2, group_o;
  logic [15:0] mtx_row_i = 16'h0, out_req_i = 16'h0, rd_data_o, out_o;
  ssd_rd_req_type rd_req_i = '0;
  logic rd_valid_o, restart_o, health_o, status_led_o, panel_fault_o;
  ssd_event_type event_o;
  int mismatches = 0, samples_checked = 0, n;

  ssd_top #(.TIMEOUT_CYC(8), .RESTART_LEN(2), .RECOVER_LEN(8)) DUT (.mclk_i, .rst_i, .kick_i, .boot_ok_i,
    .supply_ok_i, .alarm_src_i, .relay_fault_i, .alarm_out_fault_i, .hw_fault_i, .cfg_we_i, .cfg_src_i,
    .cfg_group_i, .link_we_i, .link_i, .mtx_we_i, .mtx_group_i, .mtx_row_i, .panel_reset_i, .out_req_i,
    .rd_req_i, .rd_data_o, .rd_valid_o, .restart_o, .health_o, .status_led_o, .panel_fault_o, .group_o,
    .out_o, .event_o);
  ssd_ctrl_model #(.KICK_GAP(4)) ctrl (.mclk_i, .stall_i(stall), .kick_o(kick_i));

  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic step(input int k);
    repeat (k) @(negedge mclk_i);
  endtask

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held through the edge; the caller drops rd after the last one
  task automatic read_chk(input logic [1:0] idx, input logic [15:0] exp);
    rd_req_i = '{rd: 1'b1, idx: idx};
    step(1);
    check("read valid", 24'h1, {23'h0, rd_valid_o});
    check("read data", {8'h0, exp}, {8'h0, rd_data_o});
  endtask

  // other queued events may come first, so scan a bounded window
  task automatic expect_event(input logic [7:0] code, input logic [4:0] src);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 12 && !seen; i++) begin
      step(1);
      seen = event_o.valid === 1'b1 && event_o.code === code && event_o.source === src;
    end
    check("event", 24'h1, {23'h0, seen});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles of the tests
  initial begin
    #(3000 * 40);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    step(20);
    rst_i = 1'b0;
    step(30);
    check("health idle", 24'h1, {23'h0, health_o});
    check("groups idle", 24'h0, {21'h0, group_o});
    $display("test defaults done");
    // group one drives output six through the matrix
    mtx_row_i = 16'h0020;
    mtx_we_i = 1'b1;
    step(1);
    mtx_we_i = 1'b0;
    alarm_src_i[3] = 1'b1;
    expect_event(DIAG_ON_EVENT, 5'h3);
    step(2);
    check("group one", 24'h1, {21'h0, group_o});
    check("health unlinked", 24'h1, {23'h0, health_o});
    check("matrix out", 24'h20, {8'h0, out_o});
    alarm_src_i[3] = 1'b0;
    expect_event(DIAG_OFF_EVENT, 5'h3);
    step(3);
    check("latched group", 24'h1, {21'h0, group_o});
    link_i = 3'h1;
    link_we_i = 1'b1;
    step(1);
    link_we_i = 1'b0;
    step(3);
    check("health linked", 24'h0, {23'h0, health_o});
    panel_reset_i = 1'b1;
    step(1);
    panel_reset_i = 1'b0;
    step(3);
    check("group cleared", 24'h0, {21'h0, group_o});
    check("health back", 24'h1, {23'h0, health_o});
    cfg_src_i = 5'h4;
    cfg_group_i = 2'h2;
    cfg_we_i = 1'b1;
    step(1);
    cfg_we_i = 1'b0;
    alarm_src_i[4] = 1'b1;
    step(3);
    check("group three", 24'h4, {21'h0, group_o});
    alarm_src_i[4] = 1'b0;
    $display("test grouping done");
    supply_ok_i = 1'b0;
    step(3);
    check("health no supply", 24'h0, {23'h0, health_o});
    supply_ok_i = 1'b1;
    step(2);
    check("health supply back", 24'h1, {23'h0, health_o});
    hw_fault_i = 10'h001;
    expect_event(DIAG_ON_EVENT, 5'h8);
    check("health supply fault", 24'h0, {23'h0, health_o});
    relay_fault_i = 24'h9A5C3F;
    alarm_out_fault_i = 5'h15;
    hw_fault_i = 10'h2B6;
    step(1);
    read_chk(REG_RELAY_LOW, {relay_fault_i[8], alarm_out_fault_i, relay_fault_i[7:0], 2'h0});
    read_chk(REG_RELAY_HIGH, {1'h0, relay_fault_i[23:9]});
    read_chk(REG_RESERVED, 16'h0000);
    read_chk(REG_HW_FAULTS, {6'h00, hw_fault_i});
    rd_req_i = '0;
    $display("test registers done");
    stall = 1'b1;
    for (int i = 0; i < 40 && restart_o !== 1'b1; i++) step(1);
    for (n = 0; n < 10 && restart_o === 1'b1; n++) step(1);
    check("restart length", 24'h2, n[23:0]);
    stall = 1'b0;
    step(30);
    check("recovered", 24'h0, {23'h0, status_led_o});
    stall = 1'b1;
    out_req_i = 16'hFFFF;
    for (int i = 0; i < 80 && status_led_o !== 1'b1; i++) step(1);
    check("permanent", 24'h1, {23'h0, status_led_o});
    step(2);
    check("outputs blocked", 24'h0, {8'h0, out_o});
    check("health released", 24'h0, {23'h0, health_o});
    check("panel message", 24'h1, {23'h0, panel_fault_o});
    $display("test watchdog done");
    rst_i = 1'b1;
    stall = 1'b0;
    boot_ok_i = 1'b0;
    step(20);
    rst_i = 1'b0;
    step(60);
    check("boot failure", 24'h1, {23'h0, status_led_o});
    $display("test boot done");
    tally_and_finish();
  end
endmodule

bind ssd_top ssd_top_props #(.TIMEOUT_CYC(TIMEOUT_CYC), .RESTART_LEN(RESTART_LEN), .RECOVER_LEN(RECOVER_LEN))
  u_props (.mclk_i, .rst_i, .supply_ok_i, .relay_fault_i, .alarm_out_fault_i, .hw_fault_i, .rd_req_i,
  .rd_data_o, .rd_valid_o, .health_o, .status_led_o, .panel_fault_o, .restart_o, .out_o, .event_o);
